/* rtl/dbs_steer_dev.sv */
`timescale 1ns/1ns
module dbs_steer_dev import dbs_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   dbs_bus_if.dev           bus,
   input  wire logic        dram_timing_clock,
   input  wire logic [15:0] dram_rdata,
   input  wire logic [1:0]  byte_parity_i,
   output      logic [1:0]  byte_parity_o,
   output      logic [1:0]  byte_parity_oe,
   output      logic        sys_addr_lsb,
   output      logic [2:0]  sys_addr_upper,
   output      logic [11:0] dram_mux_addr,
   output      logic [1:0]  ras_n,
   output      logic [1:0]  cas_n,
   output      logic        dram_write_n,
   output      logic        dram_buffer_enable_n,
   output      logic        sysbus_buffer_enable_n,
   output      logic        parity_fault,
   output      logic        rom_sel_n
);
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_DEC  = 3'b001,
      ST_RAS  = 3'b010,
      ST_CAS  = 3'b011,
      ST_SD   = 3'b100,
      ST_DONE = 3'b101
   } dbs_st_e;

   dbs_st_e          st_r;
   dbs_st_e          st_nxt;
   logic [19:0]      addr_r;
   logic [15:0]      wdata_r;
   logic [15:0]      rdata_r;
   logic             mem_r, wr_r, bhe_n_r, ref_r;
   logic [CFG_W-1:0] cfg_r;
   logic [5:0]       idx_r;
   logic [MAPW-1:0]  map_r [0:MAP_N-1];
   logic [2:0]       tcnt_r;
   logic [2:0]       clk_s_r;
   logic             clk_lvl_r;
   logic             phase_r, sd_lsb_r;
   logic [7:0]       sd_wd_r;
   logic [11:0]      ma_r;
   logic [1:0]       ras_r, cas_r, par_r, par_oe_r;
   logic             dwr_r, fault_r;
   logic [11:0]      row, col;
   logic             cas_odd;

   // Address latch at cycle start
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         {addr_r, wdata_r} <= {20'h00000, 16'h0000};
         {mem_r, wr_r, bhe_n_r, ref_r} <= 4'h2;
      end
      else if (bus.cyc_start)
      begin
         addr_r  <= bus.cyc_addr;
         wdata_r <= bus.cyc_wdata;
         mem_r   <= bus.cyc_mem;
         wr_r    <= bus.cyc_wr;
         bhe_n_r <= bus.cyc_bhe_n;
         ref_r   <= !bus.refresh_ack_n;
      end
   end

   // Timing clock pin: three stages, edge once stages two and three agree
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         clk_s_r   <= 3'h0;
         clk_lvl_r <= 1'b0;
      end
      else
      begin
         clk_s_r <= {clk_s_r[1:0], dram_timing_clock};
         if (clk_s_r[1] == clk_s_r[2]) clk_lvl_r <= clk_s_r[2];
      end
   end
   wire tick = clk_s_r[1] && clk_s_r[2] && !clk_lvl_r;

   // Window decode and translation
   wire [5:0]      win     = addr_r[19:14];
   wire            fixed   = win >= FIXED_WIN;
   wire [MAPW-1:0] map_ent = fixed ? 12'h000 : map_r[win];
   wire            map_hit = cfg_r[CFG_MAPEN] && !fixed && map_ent[MAP_EN_BIT];
   wire [DAW-1:0]  dram_ba = map_hit ? {map_ent[SEG_W-1:0], addr_r[13:0]} : {5'h00, addr_r};
   wire [23:0]     wa      = dram_ba[DAW-1:1];

   // Target classification
   wire [7:0] io_page  = addr_r[15:8];
   wire       is_rom   = mem_r && fixed && !ref_r;
   wire       is_dram  = ref_r || (mem_r && !fixed && (win < SD_WIN_LO || map_hit));
   wire       own_io   = !mem_r && io_page == OWN_IO_PAGE;
   wire       local_io = own_io || (!mem_r && (io_page == CPU_IO_PAGE || io_page == CMP_IO_PAGE
                                               || io_page == FPU_IO_PAGE));
   wire       noioref  = cfg_r[CFG_NOIOREF];
   wire       nbl_low  = ref_r ? noioref : (is_dram || is_rom || local_io);
   wire       lo_en    = !addr_r[0];
   wire       hi_en    = !bhe_n_r;
   wire       split    = lo_en && hi_en;
   wire [2:0] t_len    = cfg_r[CFG_SLOW] ? DRAM_T_SLOW : DRAM_T_FAST;
   wire [1:0] bank_sz  = cfg_r[CFG_BANK_LO +: 2];
   wire       ext_sd   = mem_r ? bus.offboard_mem_flag : bus.offboard_io_flag;

   // Row, column and bank select per bank size
   always_comb
   begin
      case (bank_sz)
         BANK_1M:
         begin
            row     = {wa[22:21], wa[19:10]};
            col     = {wa[22:21], wa[9:0]};
            cas_odd = wa[20];
         end
         BANK_4M:
         begin
            row     = {wa[23], wa[21:11]};
            col     = {wa[23], wa[10:0]};
            cas_odd = wa[22];
         end
         default:
         begin
            row     = {wa[21:19], wa[17:9]};
            col     = {wa[21:19], wa[8:0]};
            cas_odd = wa[18];
         end
      endcase
   end

   // Cycle events
   wire go_ras   = st_r == ST_DEC && !own_io && is_dram;
   wire go_cas   = st_r == ST_RAS && tick;
   wire dram_end = st_r == ST_CAS && tick && tcnt_r == t_len;
   wire sd_take  = st_r == ST_SD && bus.sd_ack;
   wire sd_more  = sd_take && split && !phase_r && !ref_r;
   wire own_wr   = st_r == ST_DEC && own_io && wr_r;
   wire own_rd   = st_r == ST_DEC && own_io && !wr_r;

   // Sequencer
   always_comb
   begin
      case (st_r)
         ST_IDLE: st_nxt = bus.cyc_start ? ST_DEC : ST_IDLE;
         ST_DEC:
         begin
            if (own_io)                          st_nxt = ST_DONE;
            else if (is_dram)                    st_nxt = ST_RAS;
            else if (!bus.narrow_bus_location_n) st_nxt = ST_DONE;
            else                                 st_nxt = ST_SD;
         end
         ST_RAS:  st_nxt = tick ? ST_CAS : ST_RAS;
         ST_CAS:  st_nxt = !dram_end ? ST_CAS : ((ref_r && !noioref) ? ST_SD : ST_DONE);
         ST_SD:   st_nxt = (sd_take && !sd_more) ? ST_DONE : ST_SD;
         ST_DONE: st_nxt = ST_IDLE;
         default: st_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst) st_r <= ST_IDLE;
      else         st_r <= st_nxt;
   end

   // Tick counter within a DRAM access
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)                tcnt_r <= 3'h1;
      else if (go_cas)            tcnt_r <= 3'h2;
      else if (st_r == ST_CAS && tick) tcnt_r <= tcnt_r + 3'h1;
   end

   // DRAM strobes and mux address
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || dram_end)
      begin
         ras_r <= 2'h3;
         cas_r <= 2'h3;
         dwr_r <= 1'b1;
      end
      else if (go_ras) ras_r <= ref_r ? 2'h0 : ~{hi_en, lo_en};
      else if (go_cas && !ref_r)
      begin
         cas_r <= cas_odd ? 2'h1 : 2'h2;
         dwr_r <= !wr_r;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)     ma_r <= 12'h000;
      else if (go_ras) ma_r <= ref_r ? addr_r[11:0] : row;
      else if (go_cas) ma_r <= col;
   end

   // Write parity, odd per byte
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || dram_end)
      begin
         par_r    <= 2'h0;
         par_oe_r <= 2'h0;
      end
      else if (go_ras && wr_r && !ref_r)
      begin
         par_r    <= {~^wdata_r[15:8], ~^wdata_r[7:0]};
         par_oe_r <= 2'h3;
      end
   end

   // Read parity check on the lanes read; a new fault beats the clear
   wire bad_lo = lo_en && !(^{dram_rdata[7:0], byte_parity_i[0]});
   wire bad_hi = hi_en && !(^{dram_rdata[15:8], byte_parity_i[1]});
   wire par_set = dram_end && !wr_r && !ref_r && (bad_lo || bad_hi);
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)             fault_r <= 1'b0;
      else if (par_set)        fault_r <= 1'b1;
      else if (bus.cyc_start)  fault_r <= 1'b0;
   end

   // Narrow bus lane steering and double cycle
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         {phase_r, sd_lsb_r, sd_wd_r} <= {1'b0, 1'b0, 8'h00};
      end
      else if (st_r == ST_DEC)
      begin
         phase_r  <= 1'b0;
         sd_lsb_r <= addr_r[0];
         sd_wd_r  <= addr_r[0] ? wdata_r[15:8] : wdata_r[7:0];
      end
      else if (sd_more)
      begin
         phase_r  <= 1'b1;
         sd_lsb_r <= 1'b1;
         sd_wd_r  <= wdata_r[15:8];
      end
   end

   // Entry selected by the index port, zero past the last window
   wire [MAPW-1:0] map_ent_idx = (idx_r < 6'(MAP_N)) ? map_r[idx_r] : 12'h000;

   // Read data gathering
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || bus.cyc_start)     rdata_r <= 16'h0000;
      else if (dram_end && !ref_r)      rdata_r <= dram_rdata;
      else if (sd_take && sd_lsb_r)     rdata_r[15:8] <= bus.sd_rdata;
      else if (sd_take)                 rdata_r[7:0]  <= bus.sd_rdata;
      else if (own_rd && addr_r[15:0] == CFG_PORT) rdata_r <= {10'h000, fault_r, cfg_r};
      else if (own_rd && addr_r[15:0] == IDX_PORT) rdata_r <= {10'h000, idx_r};
      else if (own_rd && addr_r[15:0] == MAP_PORT) rdata_r <= {4'h0, map_ent_idx};
   end

   // Own configuration ports
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         cfg_r <= CFG_RST;
         idx_r <= 6'h00;
      end
      else if (own_wr && addr_r[15:0] == CFG_PORT) cfg_r <= wdata_r[CFG_W-1:0];
      else if (own_wr && addr_r[15:0] == IDX_PORT) idx_r <= wdata_r[5:0];
   end

   // Mapping register file, one entry per window below FIXED_WIN
   genvar gi;
   generate
      for (gi = 0; gi < MAP_N; gi++)
      begin : g_map
         always_ff @(posedge sys_clk)
         begin
            if (sys_rst) map_r[gi] <= 12'h000;
            else if (own_wr && addr_r[15:0] == MAP_PORT && idx_r == 6'(gi))
               map_r[gi] <= wdata_r[MAPW-1:0];
         end
      end
   endgenerate

   // Outputs
   assign bus.nbl_dev_o          = 1'b0;
   assign bus.nbl_dev_oe         = st_r != ST_IDLE && nbl_low;
   assign bus.sd_req             = st_r == ST_SD;
   assign bus.sd_wdata           = sd_wd_r;
   assign bus.cyc_done           = st_r == ST_DONE;
   assign bus.cyc_rdata          = rdata_r;
   assign sysbus_buffer_enable_n = !(st_r == ST_SD && ext_sd);
   assign dram_buffer_enable_n   = !(st_r == ST_CAS && !ref_r);
   assign rom_sel_n              = !(st_r != ST_IDLE && is_rom);
   assign sys_addr_lsb           = sd_lsb_r;
   assign sys_addr_upper         = addr_r[19:17];
   assign dram_mux_addr          = ma_r;
   assign ras_n                  = ras_r;
   assign cas_n                  = cas_r;
   assign dram_write_n           = dwr_r;
   assign byte_parity_o          = par_r;
   assign byte_parity_oe         = par_oe_r;
   assign parity_fault           = fault_r;
endmodule

/* rtl/dbs_pkg.sv */
package dbs_pkg;
   // Bus widths
   localparam int AW    = 20;
   localparam int DW    = 16;
   localparam int BW    = 8;
   localparam int MAPW  = 12;
   localparam int MAP_N = 60;
   localparam int WINW  = 6;
   localparam int MAW   = 12;
   localparam int DAW   = 25;

   // Window 60 starts at F0000, never translated
   localparam logic [5:0] FIXED_WIN   = 6'h3c;
   // First window of the adapter hole at A0000
   localparam logic [5:0] SD_WIN_LO   = 6'h28;
   // Mapping entry: enable bit and segment field
   localparam int         MAP_EN_BIT  = 11;
   localparam int         SEG_W       = 11;

   // Local IO pages that claim the local bus
   localparam logic [7:0] CPU_IO_PAGE = 8'hff;
   localparam logic [7:0] CMP_IO_PAGE = 8'hfd;
   localparam logic [7:0] OWN_IO_PAGE = 8'hfc;
   localparam logic [7:0] FPU_IO_PAGE = 8'hf8;
   // Own IO ports
   localparam logic [15:0] CFG_PORT   = 16'hfc80;
   localparam logic [15:0] IDX_PORT   = 16'hfc82;
   localparam logic [15:0] MAP_PORT   = 16'hfc84;

   // Config register layout
   localparam int         CFG_W       = 5;
   localparam int         CFG_BANK_LO = 0;
   localparam int         CFG_SLOW    = 2;
   localparam int         CFG_NOIOREF = 3;
   localparam int         CFG_MAPEN   = 4;
   localparam logic [4:0] CFG_RST     = 5'h00;
   localparam int         STAT_FAULT  = 5;

   // DRAM access length in timing-clock ticks
   localparam logic [2:0] DRAM_T_FAST = 3'h4;
   localparam logic [2:0] DRAM_T_SLOW = 3'h5;

   typedef enum logic [1:0]
   {
      BANK_256K = 2'b00,
      BANK_1M   = 2'b01,
      BANK_4M   = 2'b10
   } dbs_bank_e;
endpackage

/* rtl/dbs_bus_if.sv */
`timescale 1ns/1ns
interface dbs_bus_if #(parameter logic EXT_BUF = 1'b1);
   logic        cyc_start;
   logic [19:0] cyc_addr;
   logic        cyc_bhe_n;
   logic        cyc_mem;
   logic        cyc_wr;
   logic        refresh_ack_n;
   logic [15:0] cyc_wdata;
   logic        cyc_done;
   logic [15:0] cyc_rdata;
   logic        sd_req;
   logic [7:0]  sd_wdata;
   logic        sd_ack;
   logic [7:0]  sd_rdata;
   logic        nbl_dev_o;
   logic        nbl_dev_oe;
   logic        nbl_host_o;
   logic        nbl_host_oe;
   logic        offmem_o;
   logic        offmem_oe;
   logic        offio_o;
   logic        offio_oe;
   wire         narrow_bus_location_n;
   wire         offboard_mem_flag;
   wire         offboard_io_flag;

   // Open-drain lines, pulled up; flags tied low without an external buffer
   assign narrow_bus_location_n = !((nbl_dev_oe && !nbl_dev_o) || (nbl_host_oe && !nbl_host_o));
   assign offboard_mem_flag     = EXT_BUF && !(offmem_oe && !offmem_o);
   assign offboard_io_flag      = EXT_BUF && !(offio_oe && !offio_o);

   modport dev
   (
      input  cyc_start, cyc_addr, cyc_bhe_n, cyc_mem, cyc_wr, refresh_ack_n, cyc_wdata,
      input  sd_ack, sd_rdata, narrow_bus_location_n, offboard_mem_flag, offboard_io_flag,
      output cyc_done, cyc_rdata, sd_req, sd_wdata, nbl_dev_o, nbl_dev_oe
   );
   modport host
   (
      output cyc_start, cyc_addr, cyc_bhe_n, cyc_mem, cyc_wr, refresh_ack_n, cyc_wdata,
      output sd_ack, sd_rdata, nbl_host_o, nbl_host_oe, offmem_o, offmem_oe, offio_o, offio_oe,
      input  cyc_done, cyc_rdata, sd_req, sd_wdata, narrow_bus_location_n
   );
endinterface

/* rtl/dbs_host_end.sv */
`timescale 1ns/1ns
module dbs_host_end import dbs_pkg::*;
#(
   parameter int SD_T = 4
)
(
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   dbs_bus_if.host          bus,
   input  wire logic        req_valid,
   output      logic        req_ready,
   input  wire logic        req_mem,
   input  wire logic        req_write,
   input  wire logic [19:0] req_addr,
   input  wire logic        req_bhe_n,
   input  wire logic [15:0] req_wdata,
   input  wire logic        req_ext_local,
   input  wire logic        req_int_mem,
   input  wire logic        req_int_io,
   input  wire logic        req_int_dma,
   input  wire logic        dma_address_enable,
   input  wire logic [2:0]  dma_channel_ack_n,
   input  wire logic        refresh_req,
   output      logic        rsp_valid,
   output      logic [15:0] rsp_rdata,
   output      logic        rom_output_enable_n,
   output      logic        transfer_direction,
   output      logic        sd_rd_n,
   output      logic        sd_wr_n,
   output      logic [7:0]  sd_data_o,
   input  wire logic [7:0]  sd_data_i
);
   typedef enum logic [1:0]
   {
      H_IDLE  = 2'b00,
      H_START = 2'b01,
      H_WAIT  = 2'b10
   } dbs_hst_e;

   dbs_hst_e    st_r;
   dbs_hst_e    st_nxt;
   logic [19:0] addr_r;
   logic [15:0] wdata_r;
   logic        mem_r, wr_r, bhe_n_r, ref_r, ext_r, imem_r, iio_r, idma_r;
   logic        sd_busy_r, sd_ack_r, rsp_r;
   logic [7:0]  sd_rd_r, sd_wd_r;
   logic [15:0] rsp_d_r;
   logic [7:0]  sd_cnt_r;
   wire         busy    = st_r != H_IDLE;
   wire         take    = st_r == H_IDLE && (refresh_req || req_valid);
   wire         sd_go   = bus.sd_req && !sd_busy_r && !sd_ack_r;
   wire         sd_last = sd_busy_r && sd_cnt_r == 8'(SD_T - 1);

   // Cycle sequencer
   always_comb
   begin
      case (st_r)
         H_IDLE:  st_nxt = take ? H_START : H_IDLE;
         H_START: st_nxt = H_WAIT;
         H_WAIT:  st_nxt = bus.cyc_done ? H_IDLE : H_WAIT;
         default: st_nxt = H_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst) st_r <= H_IDLE;
      else         st_r <= st_nxt;
   end

   // Request capture; refresh takes precedence
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         {addr_r, wdata_r, bhe_n_r} <= {20'h00000, 16'h0000, 1'b1};
         {mem_r, wr_r, ref_r, ext_r, imem_r, iio_r, idma_r} <= 7'h00;
      end
      else if (take)
      begin
         ref_r   <= refresh_req;
         mem_r   <= refresh_req || req_mem;
         wr_r    <= !refresh_req && req_write;
         addr_r  <= refresh_req ? 20'h00000 : req_addr;
         bhe_n_r <= refresh_req || req_bhe_n;
         wdata_r <= req_wdata;
         ext_r   <= !refresh_req && req_ext_local;
         imem_r  <= req_int_mem;
         iio_r   <= req_int_io;
         idma_r  <= req_int_dma;
      end
   end

   // Refresh row counter travels in the low address bits
   logic [11:0] ref_row_r;
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)                ref_row_r <= 12'h000;
      else if (take && refresh_req) ref_row_r <= ref_row_r + 12'h001;
   end

   assign req_ready          = st_r == H_IDLE && !refresh_req;
   assign bus.cyc_start      = st_r == H_START;
   assign bus.cyc_addr       = ref_r ? {8'h00, ref_row_r} : addr_r;
   assign bus.cyc_bhe_n      = bhe_n_r;
   assign bus.cyc_mem        = mem_r;
   assign bus.cyc_wr         = wr_r;
   assign bus.cyc_wdata      = wdata_r;
   assign bus.refresh_ack_n  = !(busy && ref_r);
   assign rom_output_enable_n = !(busy && !wr_r);
   assign transfer_direction = busy && wr_r;

   // Open-drain claims of the far-side devices
   assign bus.nbl_host_o  = 1'b0;
   assign bus.nbl_host_oe = busy && ext_r && !ref_r;
   assign bus.offmem_o    = 1'b0;
   assign bus.offmem_oe   = busy && imem_r && !ref_r;
   assign bus.offio_o     = 1'b0;
   assign bus.offio_oe    = busy && ((iio_r && !dma_address_enable)
                                     || (idma_r && dma_channel_ack_n != 3'h7));

   // Narrow bus cycle engine of fixed length
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         {sd_busy_r, sd_ack_r, sd_cnt_r, sd_rd_r, sd_wd_r} <= {1'b0, 1'b0, 8'h00, 8'h00, 8'h00};
      end
      else
      begin
         sd_ack_r <= sd_last;
         if (sd_go)
         begin
            sd_busy_r <= 1'b1;
            sd_cnt_r  <= 8'h00;
            sd_wd_r   <= bus.sd_wdata;
         end
         else if (sd_last)
         begin
            sd_busy_r <= 1'b0;
            sd_rd_r   <= sd_data_i;
         end
         else if (sd_busy_r) sd_cnt_r <= sd_cnt_r + 8'h01;
      end
   end

   assign bus.sd_ack   = sd_ack_r;
   assign bus.sd_rdata = sd_rd_r;
   assign sd_rd_n      = !(sd_busy_r && !wr_r);
   assign sd_wr_n      = !(sd_busy_r && wr_r);
   assign sd_data_o    = sd_wd_r;

   // Answer to the requester
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         rsp_r   <= 1'b0;
         rsp_d_r <= 16'h0000;
      end
      else
      begin
         rsp_r <= st_r == H_WAIT && bus.cyc_done && !ref_r;
         if (st_r == H_WAIT && bus.cyc_done) rsp_d_r <= bus.cyc_rdata;
      end
   end

   assign rsp_valid = rsp_r;
   assign rsp_rdata = rsp_d_r;
endmodule

/* tb/dbs_bus_chk.sv */
`timescale 1ns/1ns
module dbs_bus_chk import dbs_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic        cyc_start,
   input wire logic [19:0] cyc_addr,
   input wire logic        cyc_bhe_n,
   input wire logic        cyc_mem,
   input wire logic        cyc_wr,
   input wire logic        refresh_ack_n,
   input wire logic [15:0] cyc_wdata,
   input wire logic        cyc_done,
   input wire logic [7:0]  sd_wdata,
   input wire logic        sd_ack,
   input wire logic        nbl_dev_oe,
   input wire logic        nbl_host_oe,
   input wire logic        offmem_oe
);
   logic [1:0] ack_cnt_r;
   // Local targets: DRAM, ROM and the four local IO pages
   wire  [7:0] page_w  = cyc_addr[15:8];
   wire        local_w = cyc_mem ? (cyc_addr < 20'ha0000 || cyc_addr >= 20'hf0000)
                         : (page_w inside {CPU_IO_PAGE, CMP_IO_PAGE, OWN_IO_PAGE, FPU_IO_PAGE});
   wire        hole_w  = cyc_mem && cyc_addr >= 20'ha0000 && cyc_addr < 20'hf0000;
   // Counts narrow byte handshakes within one cycle
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || cyc_start)
         ack_cnt_r <= 2'h0;
      else if (sd_ack)
         ack_cnt_r <= ack_cnt_r + 2'h1;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   AST_NBL_LOCAL: assert property (cyc_start && refresh_ack_n && local_w |-> ##[1:2] nbl_dev_oe)
      else $error("Location line not pulled for a local target");
   AST_NBL_NARROW: assert property (cyc_start && refresh_ack_n && hole_w |=> !nbl_dev_oe [*2])
      else $error("Location line pulled for a narrow target");
   AST_WORD_SPLIT: assert property (cyc_done && refresh_ack_n && ack_cnt_r != 2'h0
      |-> ack_cnt_r == ((!cyc_bhe_n && !cyc_addr[0]) ? 2'h2 : 2'h1)) else $error("Wrong narrow cycle count");
   AST_SD_LANE: assert property (sd_ack && cyc_wr && refresh_ack_n && (cyc_bhe_n || cyc_addr[0])
      |-> sd_wdata == (cyc_addr[0] ? cyc_wdata[15:8] : cyc_wdata[7:0])) else $error("Wrong byte lane");
   AST_ADDR_HOLD: assert property (cyc_start |=> ($stable(cyc_addr) && $stable(cyc_wdata)) until_with cyc_done)
      else $error("Cycle fields moved before done");
   AST_DONE_BOUND: assert property (cyc_start |-> ##[2:300] cyc_done)
      else $error("Cycle not finished in time");
   AST_REF_NBL: assert property (!refresh_ack_n |-> !nbl_host_oe)
      else $error("Location line claimed in refresh");
   AST_REF_MEM: assert property (!refresh_ack_n |-> !offmem_oe)
      else $error("Memory flag claimed in refresh");
   cover property (cyc_done && ack_cnt_r == 2'h2);
   cover property (cyc_start && !refresh_ack_n);
   cover property (cyc_start && cyc_wr && hole_w);
endmodule

/* tb/test_dram_bus_steering_ctrl.sv */
`timescale 1ns/1ns
module test_dram_bus_steering_ctrl import dbs_pkg::*;;
   logic        sys_clk = 1'b0, sys_rst = 1'b1, dram_timing_clock = 1'b0, req_valid = 1'b0;
   logic        req_mem = 1'b0, req_write = 1'b0, req_bhe_n = 1'b0, refresh_req = 1'b0, int_mem = 1'b0;
   logic        ext_loc = 1'b0, int_io = 1'b0;
   logic [19:0] req_addr = 20'h00000;
   logic [15:0] req_wdata = 16'h0000, dram_rdata = 16'h0000, rsp_rdata, v;
   logic [1:0]  par_i = 2'h3, par_o, par_oe, ras_n, cas_n, cas_seen;
   logic        req_ready, rsp_valid, rom_oe_n, dir, sd_rd_n, sd_wr_n, sa_lsb, dwr_n, dram_buffer_enable_n_n, sysbus_buffer_enable_n_n;
   logic        pfault, rom_n, rom_seen, sysbus_buffer_enable_n_seen;
   logic [7:0]  sd_data_o;
   logic [2:0]  sa_up;
   logic [11:0] ma;
   integer      fails = 0, checked = 0, seed = 32'h7ce4, i, n;
   // Narrow bus answers a distinct byte per address parity
   wire  [7:0]  sd_data_i = sa_lsb ? 8'hb6 : 8'h4a;
   always #4 sys_clk = ~sys_clk;
   // Slow enough for the pin filter to see each level twice
   always #16 dram_timing_clock = ~dram_timing_clock;
   dbs_bus_if #(.EXT_BUF(1'b1)) i_dbs_bus_if ();
   dbs_host_end #(.SD_T(4)) i_dbs_host_end (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(i_dbs_bus_if),
      .req_valid(req_valid), .req_ready(req_ready), .req_mem(req_mem), .req_write(req_write),
      .req_addr(req_addr), .req_bhe_n(req_bhe_n), .req_wdata(req_wdata), .req_ext_local(ext_loc),
      .req_int_mem(int_mem), .req_int_io(int_io), .req_int_dma(1'b0), .dma_address_enable(1'b0),
      .dma_channel_ack_n(3'h7), .refresh_req(refresh_req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .rom_output_enable_n(rom_oe_n), .transfer_direction(dir), .sd_rd_n(sd_rd_n), .sd_wr_n(sd_wr_n),
      .sd_data_o(sd_data_o), .sd_data_i(sd_data_i));
   dbs_steer_dev i_dbs_steer_dev (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(i_dbs_bus_if),
      .dram_timing_clock(dram_timing_clock), .dram_rdata(dram_rdata), .byte_parity_i(par_i),
      .byte_parity_o(par_o), .byte_parity_oe(par_oe), .sys_addr_lsb(sa_lsb), .sys_addr_upper(sa_up),
      .dram_mux_addr(ma), .ras_n(ras_n), .cas_n(cas_n), .dram_write_n(dwr_n),
      .dram_buffer_enable_n(dram_buffer_enable_n_n), .sysbus_buffer_enable_n(sysbus_buffer_enable_n_n), .parity_fault(pfault), .rom_sel_n(rom_n));
   dbs_bus_chk i_dbs_bus_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .cyc_start(i_dbs_bus_if.cyc_start),
      .cyc_addr(i_dbs_bus_if.cyc_addr), .cyc_bhe_n(i_dbs_bus_if.cyc_bhe_n), .cyc_mem(i_dbs_bus_if.cyc_mem),
      .cyc_wr(i_dbs_bus_if.cyc_wr), .refresh_ack_n(i_dbs_bus_if.refresh_ack_n),
      .cyc_wdata(i_dbs_bus_if.cyc_wdata), .cyc_done(i_dbs_bus_if.cyc_done), .sd_wdata(i_dbs_bus_if.sd_wdata),
      .sd_ack(i_dbs_bus_if.sd_ack), .nbl_dev_oe(i_dbs_bus_if.nbl_dev_oe),
      .nbl_host_oe(i_dbs_bus_if.nbl_host_oe), .offmem_oe(i_dbs_bus_if.offmem_oe));
   // Odd parity of each byte
   function automatic logic [1:0] opar(input logic [15:0] d);
      return {~^d[15:8], ~^d[7:0]};
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked = checked + 1;
      if (seen !== exp)
      begin
         fails = fails + 1;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task complete_run;
      if (fails == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // One request, held until taken, then wait for the answer
   task automatic op(input logic m, input logic w, input logic [19:0] a, input logic b, input logic [15:0] d);
      req_valid <= 1'b1;
      req_mem <= m;
      req_write <= w;
      req_addr <= a;
      req_bhe_n <= b;
      req_wdata <= d;
      do @(negedge sys_clk); while (req_ready !== 1'b1);
      @(posedge sys_clk);
      req_valid <= 1'b0;
      n = 0;
      do @(negedge sys_clk); while (rsp_valid !== 1'b1 && n++ < 400);
      check(16'(rsp_valid), 16'h0001);
      @(posedge sys_clk);
   endtask
   // Strobe watchers and write parity on the DRAM pins
   always @(negedge sys_clk)
   begin
      if (cas_n !== 2'b11)
         cas_seen = cas_n;
      if (rom_n === 1'b0)
         rom_seen = 1'b1;
      if (sysbus_buffer_enable_n_n === 1'b0)
         sysbus_buffer_enable_n_seen = 1'b1;
      if (dwr_n === 1'b0)
         check(16'({par_oe, par_o}), 16'({2'b11, opar(req_wdata)}));
   end
   initial
   begin
      #60000;
      fails = fails + 1;
      complete_run();
   end
   initial
   begin
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      op(1'b0, 1'b1, {4'h0, CFG_PORT}, 1'b0, 16'h0004);
      op(1'b0, 1'b0, {4'h0, CFG_PORT}, 1'b0, 16'h0000);
      check(rsp_rdata, 16'h0004);
      for (i = 0; i < 4; i++)
         op(1'b1, 1'b1, 20'($random(seed)) & 20'h7fffe, 1'b0, 16'($random(seed)));
      // Word, even byte, odd byte and word reads, parity slips on the last three
      for (i = 0; i < 4; i++)
      begin
         v = 16'($random(seed));
         dram_rdata <= v;
         par_i <= opar(v) ^ (i == 3 ? 2'b01 : (i > 0 ? 2'b10 : 2'b00));
         cas_seen = 2'b11;
         op(1'b1, 1'b0, i == 0 ? 20'h80000 : {19'h0, i == 2}, i == 1, 16'h0000);
         check(16'(pfault), 16'(i > 1));
         check(16'(cas_seen), i == 0 ? 16'h0001 : 16'h0002);
         if (i == 0)
            check(rsp_rdata, v);
      end
      rom_seen = 1'b0;
      sysbus_buffer_enable_n_seen = 1'b0;
      op(1'b1, 1'b0, 20'ha0000 | (20'($random(seed)) & 20'h0fffe), 1'b0, 16'h0000);
      check(rsp_rdata, 16'hb64a);
      check(16'({rom_seen, sysbus_buffer_enable_n_seen}), 16'h0001);
      op(1'b1, 1'b0, 20'ha0101, 1'b0, 16'h0000);
      check(16'(rsp_rdata[15:8]), 16'h00b6);
      op(1'b1, 1'b1, 20'ha0100, 1'b1, 16'h1234);
      int_mem <= 1'b1;
      sysbus_buffer_enable_n_seen = 1'b0;
      op(1'b1, 1'b0, 20'ha0100, 1'b1, 16'h0000);
      check(16'(sysbus_buffer_enable_n_seen), 16'h0000);
      int_mem <= 1'b0;
      int_io <= 1'b1;
      sysbus_buffer_enable_n_seen = 1'b0;
      op(1'b0, 1'b0, 20'h00301, 1'b0, 16'h0000);
      check(rsp_rdata, 16'hb600);
      check(16'(sysbus_buffer_enable_n_seen), 16'h0000);
      int_io <= 1'b0;
      ext_loc <= 1'b1;
      op(1'b1, 1'b0, 20'ha0000, 1'b0, 16'h0000);
      check(rsp_rdata, 16'h0000);
      ext_loc <= 1'b0;
      op(1'b1, 1'b0, 20'hf0000, 1'b0, 16'h0000);
      check(16'(rom_seen), 16'h0001);
      check(16'(sa_up), 16'h0007);
      refresh_req <= 1'b1;
      @(posedge sys_clk);
      refresh_req <= 1'b0;
      for (n = 0; n < 300 && ras_n !== 2'b00; n++)
         @(negedge sys_clk);
      check(16'({ras_n, cas_n}), 16'h0003);
      op(1'b0, 1'b0, {4'h0, CFG_PORT}, 1'b0, 16'h0000);
      check(rsp_rdata, 16'h0004);
      op(1'b0, 1'b1, {4'h0, IDX_PORT}, 1'b0, 16'h0028);
      op(1'b0, 1'b1, {4'h0, MAP_PORT}, 1'b0, 16'h0801);
      op(1'b0, 1'b0, {4'h0, MAP_PORT}, 1'b0, 16'h0000);
      check(rsp_rdata, 16'h0801);
      complete_run();
   end
endmodule
